// file: include/cpu_bus_defines.svh
// Numeric constants for the processor bus decode and control block.
`ifndef CPU_BUS_DEFINES_SVH
`define CPU_BUS_DEFINES_SVH
`define SYS_CLK_HZ        40000000
`define CPU_CLK_HZ        8000000
`define WAIT_STATES       3
`define RESET_HOLD_TICKS  17
`define STATUS_HALT_ACK   2'h0
`define STATUS_READ       2'h1
`define STATUS_WRITE      2'h2
`define STATUS_IDLE       2'h3
`define MEM_DRAM_LOW      4'h0
`define MEM_DRAM_HIGH     4'h1
`define MEM_VIDEO         4'h2
`define MEM_POLL          4'h3
`define MEM_UNUSED_A      4'h4
`define MEM_UNUSED_B      4'h5
`define MEM_BOOT_LOW      4'hE
`define MEM_BOOT_HIGH     4'hF
`define IO_DISPLAY_BLK    3'h0
`define IO_SERIAL_BLK     3'h1
`define IO_PARALLEL_BLK   3'h2
`define LED_RESET_VALUE   16'h0000
`endif

// file: include/cpu_bus_pkg.sv
// Types shared by the processor bus decode and control block.
package cpu_bus_pkg;

  typedef enum logic [1:0] {
    CYC_VECTOR_ACK = 2'h0,
    CYC_IO         = 2'h1,
    CYC_MEM        = 2'h2,
    CYC_FETCH      = 2'h3
  } cycle_kind_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR = 4'h2,
    ST_CMD  = 4'h4,
    ST_DONE = 4'h8
  } bus_state_t;

  typedef struct packed {
    logic [23:0] addr;
    logic        upper_byte_lane_enable_n;
    logic        mem_io_sel;
    logic        code_or_vector_ack;
    logic        cycle_status_1_n;
    logic        cycle_status_0_n;
  } cpu_status_t;

  typedef struct packed {
    logic mem_read_n;
    logic mem_write_n;
    logic io_read_n;
    logic io_write_n;
    logic vector_ack_n;
  } bus_cmd_t;

  typedef struct packed {
    logic dram_low_bank_sel_n;
    logic dram_high_bank_sel_n;
    logic video_memory_sel_n;
    logic vector_poll_sel_n;
    logic unused_region_a_sel_n;
    logic unused_region_b_sel_n;
    logic boot_memory_low_sel_n;
    logic boot_memory_high_sel_n;
    logic display_ctrl_sel_n;
    logic serial_keyboard_sel_n;
    logic parallel_adapter_sel_n;
  } chip_sel_t;

endpackage

// file: rtl/cpu_bus_decode_control.sv
// Processor bus control: clock, reset, hold, status decode, address decode and ready.
`timescale 1ns/1ps
`include "cpu_bus_defines.svh"

module cpu_bus_decode_control #(
  parameter int WAIT_STATES      = `WAIT_STATES,
  parameter int RESET_HOLD_TICKS = `RESET_HOLD_TICKS
) (
  // Clock and reset.
  input  wire logic                     clock,
  input  wire logic                     resetn,
  // Processor clock, reset and hold.
  output logic                          cpu_clk_tick,
  output logic                          cpu_reset,
  output logic                          hold_request,
  input  wire logic                     bus_release_ack,
  // Processor status and address.
  input  wire cpu_bus_pkg::cpu_status_t cpu_status,
  output logic                          ready_n,
  // Processor data bus.
  input  wire logic [15:0]              cpu_wdata,
  output logic [15:0]                   cpu_rdata,
  output logic                          cpu_rdata_oe,
  // Board pins.
  input  wire logic                     reset_button,
  input  wire logic                     run_test_selector,
  input  wire logic [3:0]               test_switch,
  output logic [15:0]                   status_led,
  // Interrupt vector source.
  input  wire logic [7:0]               irq_vector,
  // Buffered system bus.
  output logic                          addr_latch_en,
  output logic [23:0]                   sys_addr,
  output cpu_bus_pkg::bus_cmd_t         bus_cmd,
  output cpu_bus_pkg::chip_sel_t        chip_sel,
  output logic                          data_transceiver_enable,
  output logic                          data_direction,
  output logic                          byte_lane_low_en,
  output logic                          byte_lane_high_en,
  output logic [15:0]                   sys_wdata,
  input  wire logic [15:0]              sys_rdata
);
  import cpu_bus_pkg::*;

  // The ratio must be a whole number; a fractional ratio would skew the processor
  // clock enable and with it every timing count below.
  localparam int DIV_RATIO = `SYS_CLK_HZ / `CPU_CLK_HZ;

  // Lane enables from address bit 0 and the active-low high enable.
  function automatic logic [1:0] lane_decode(input logic a0, input logic bhe_n);
    lane_decode = {~bhe_n, ~a0};
  endfunction

  // Processor clock enable divided from the system clock.
  logic [7:0] div_cnt_r;
  logic       tick_r;

  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
    begin
      div_cnt_r <= 8'h00;
      tick_r    <= 1'b0;
    end
    else if (div_cnt_r == 8'(DIV_RATIO - 1))
    begin
      div_cnt_r <= 8'h00;
      tick_r    <= 1'b1;
    end
    else
    begin
      div_cnt_r <= div_cnt_r + 8'h01;
      tick_r    <= 1'b0;
    end

  assign cpu_clk_tick = tick_r;

  // Two-stage synchronisers for the board pins.
  logic [5:0] pin_meta_r;
  logic [5:0] pin_sync_r;

  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
    begin
      pin_meta_r <= 6'h01;
      pin_sync_r <= 6'h01;
    end
    else
    begin
      pin_meta_r <= {test_switch, run_test_selector, reset_button};
      pin_sync_r <= pin_meta_r;
    end

  wire       reset_req  = pin_sync_r[0];
  wire       test_mode  = pin_sync_r[1];
  wire [3:0] switch_now = pin_sync_r[5:2];

  // Processor reset, stretched past the minimum and moved on processor clock edges.
  // A press of the reset button restarts the count, so a bouncing button still
  // yields one clean release.
  logic [7:0] rst_cnt_r;
  logic       cpu_reset_r;
  logic       hold_r;

  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
    begin
      rst_cnt_r   <= 8'h00;
      cpu_reset_r <= 1'b1;
      hold_r      <= 1'b0;
    end
    else if (tick_r)
    begin
      hold_r <= test_mode;
      if (reset_req)
      begin
        rst_cnt_r   <= 8'h00;
        cpu_reset_r <= 1'b1;
      end
      else if (rst_cnt_r != 8'(RESET_HOLD_TICKS))
      begin
        rst_cnt_r   <= rst_cnt_r + 8'h01;
        cpu_reset_r <= 1'b1;
      end
      else
        cpu_reset_r <= 1'b0;
    end

  assign cpu_reset    = cpu_reset_r;
  assign hold_request = hold_r;

  // Status and cycle-type decode from the live processor lines.
  wire [1:0]  status_now = {cpu_status.cycle_status_1_n, cpu_status.cycle_status_0_n};
  wire        cycle_start = (status_now != `STATUS_IDLE) && !cpu_reset_r;
  wire [1:0]  kind_bits   = {cpu_status.mem_io_sel, cpu_status.code_or_vector_ack};

  // Bus cycle sequencer, stepped on processor clock enables.
  bus_state_t  state_r;
  cycle_kind_t kind_r;
  logic        is_read_r;
  logic        is_write_r;
  logic        ale_r;
  logic [23:0] addr_r;
  logic        bhe_n_r;
  logic [2:0]  wait_cnt_r;
  logic        ready_n_r;

  // Address and done states last one processor clock; the command state lasts until ready. Ready is registered so that the processor
  // sees it change on its own clock enable; processor reset alone can raise it in mid-period.
  wire in_cmd = (state_r == ST_CMD);
  wire idle   = (state_r == ST_IDLE);

  // Address decode from the latched address.
  // The latched copy keeps the selects steady for the whole cycle, even after the
  // processor has moved its status lines on.
  wire [3:0] mem_region = addr_r[19:16];
  wire [2:0] io_block   = addr_r[15:13];
  wire       io_upper_zero = (addr_r[23:16] == 8'h00);
  wire       mem_cyc = !idle && ((kind_r == CYC_MEM) || (kind_r == CYC_FETCH));
  wire       io_cyc  = !idle && (kind_r == CYC_IO) && io_upper_zero;
  wire       ack_cyc = !idle && (kind_r == CYC_VECTOR_ACK);

  wire sel_dram_lo  = mem_cyc && (mem_region == `MEM_DRAM_LOW);
  wire sel_dram_hi  = mem_cyc && (mem_region == `MEM_DRAM_HIGH);
  wire sel_video    = mem_cyc && (mem_region == `MEM_VIDEO);
  wire sel_poll     = (mem_cyc && (mem_region == `MEM_POLL)) || ack_cyc;
  wire sel_unused_a = mem_cyc && (mem_region == `MEM_UNUSED_A);
  wire sel_unused_b = mem_cyc && (mem_region == `MEM_UNUSED_B);
  wire sel_boot_lo  = mem_cyc && (mem_region == `MEM_BOOT_LOW);
  wire sel_boot_hi  = mem_cyc && (mem_region == `MEM_BOOT_HIGH);
  wire sel_display  = io_cyc && (io_block == `IO_DISPLAY_BLK);
  wire sel_serial   = io_cyc && (io_block == `IO_SERIAL_BLK);
  wire sel_parallel = io_cyc && (io_block == `IO_PARALLEL_BLK);

  // Fast targets answer at once; slow peripherals wait; unmapped never answers.
  // An unmapped access therefore holds the processor until the next reset.
  wire fast_target = sel_dram_lo | sel_dram_hi | sel_video | sel_poll
                   | sel_unused_a | sel_unused_b | sel_boot_lo | sel_boot_hi;
  wire slow_target = sel_display | sel_serial | sel_parallel;
  wire ready_now   = fast_target
                   | (slow_target && (wait_cnt_r == 3'(WAIT_STATES)));

  assign chip_sel = '{
    dram_low_bank_sel_n:    ~sel_dram_lo,
    dram_high_bank_sel_n:   ~sel_dram_hi,
    video_memory_sel_n:     ~sel_video,
    vector_poll_sel_n:      ~sel_poll,
    unused_region_a_sel_n:  ~sel_unused_a,
    unused_region_b_sel_n:  ~sel_unused_b,
    boot_memory_low_sel_n:  ~sel_boot_lo,
    boot_memory_high_sel_n: ~sel_boot_hi,
    display_ctrl_sel_n:     ~sel_display,
    serial_keyboard_sel_n:  ~sel_serial,
    parallel_adapter_sel_n: ~sel_parallel
  };

  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
    begin
      state_r    <= ST_IDLE;
      kind_r     <= CYC_FETCH;
      is_read_r  <= 1'b0;
      is_write_r <= 1'b0;
      ale_r      <= 1'b0;
      addr_r     <= 24'hFFFFFF;
      bhe_n_r    <= 1'b1;
      wait_cnt_r <= 3'h0;
      ready_n_r  <= 1'b1;
    end
    else if (cpu_reset_r)
    begin
      state_r   <= ST_IDLE;
      ale_r     <= 1'b0;
      ready_n_r <= 1'b1;
    end
    else if (tick_r)
    begin
      unique case (state_r)
        ST_IDLE:
          if (cycle_start)
          begin
            state_r    <= ST_ADDR;
            ale_r      <= 1'b1;
            addr_r     <= cpu_status.addr;
            bhe_n_r    <= cpu_status.upper_byte_lane_enable_n;
            kind_r     <= cycle_kind_t'(kind_bits);
            is_read_r  <= (status_now == `STATUS_READ)
                        || (status_now == `STATUS_HALT_ACK && kind_bits == 2'h0);
            is_write_r <= (status_now == `STATUS_WRITE);
          end
        ST_ADDR:
        begin
          ale_r      <= 1'b0;
          wait_cnt_r <= 3'h0;
          state_r    <= (is_read_r || is_write_r) ? ST_CMD : ST_DONE;
        end
        ST_CMD:
          if (!ready_n_r)
          begin
            ready_n_r <= 1'b1;
            state_r   <= ST_DONE;
          end
          else
          begin
            ready_n_r <= ~ready_now;
            if (wait_cnt_r != 3'(WAIT_STATES))
              wait_cnt_r <= wait_cnt_r + 3'h1;
          end
        ST_DONE:
          state_r <= ST_IDLE;
      endcase
    end

  assign ready_n       = ready_n_r;
  assign addr_latch_en = ale_r;
  assign sys_addr      = addr_r;

  // Commands and transceiver control follow the active command phase.
  wire cmd_rd = in_cmd && is_read_r;
  wire cmd_wr = in_cmd && is_write_r;

  assign bus_cmd = '{
    mem_read_n:   ~(cmd_rd && mem_cyc),
    mem_write_n:  ~(cmd_wr && mem_cyc),
    io_read_n:    ~(cmd_rd && io_cyc),
    io_write_n:   ~(cmd_wr && io_cyc),
    vector_ack_n: ~(in_cmd && ack_cyc)
  };

  // The pod owns the processor pins while hold is acknowledged.
  wire drive_ok = !bus_release_ack;

  assign data_transceiver_enable = in_cmd && (is_read_r || is_write_r);
  assign data_direction          = in_cmd && is_write_r;
  assign cpu_rdata_oe            = cmd_rd && drive_ok;

  wire [1:0] lanes = lane_decode(addr_r[0], bhe_n_r);
  assign byte_lane_low_en  = !idle && lanes[0];
  assign byte_lane_high_en = !idle && lanes[1];

  // Data registers: read return, write forward, LED latch.
  wire vector_drive = !bus_cmd.vector_ack_n && cmd_rd && sel_poll;
  logic [15:0] rdata_r;
  logic [15:0] wdata_r;
  logic [15:0] led_r;

  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
    begin
      rdata_r <= 16'h0000;
      wdata_r <= 16'h0000;
      led_r   <= `LED_RESET_VALUE;
    end
    else
    begin
      if (vector_drive)
        rdata_r <= {8'h00, irq_vector};
      else if (cmd_rd && sel_parallel)
        rdata_r <= {12'h000, switch_now};
      else if (cmd_rd)
        rdata_r <= sys_rdata;
      if (cmd_wr)
        wdata_r <= cpu_wdata;
      // LED bytes change only on processor clock enables, every enabled lane at once.
      if (cmd_wr && sel_parallel && tick_r)
      begin
        if (lanes[0])
          led_r[7:0] <= cpu_wdata[7:0];
        if (lanes[1])
          led_r[15:8] <= cpu_wdata[15:8];
      end
    end

  assign cpu_rdata  = rdata_r;
  assign sys_wdata  = wdata_r;
  assign status_led = led_r;

endmodule

// file: tb/cpu_bus_checker_assertions.sv
// Port-level assertions for the processor bus control block.
`timescale 1ns/1ps
module cpu_bus_checker
  import cpu_bus_pkg::*;
#(
  parameter int WAIT_STATES      = 3,
  parameter int RESET_HOLD_TICKS = 17
) (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        resetn,
  // Processor side.
  input wire logic        cpu_clk_tick,
  input wire logic        cpu_reset,
  input wire logic        hold_request,
  input wire logic        bus_release_ack,
  input wire logic        run_test_selector,
  input wire logic        ready_n,
  input wire logic [15:0] cpu_rdata,
  input wire logic        cpu_rdata_oe,
  input wire logic [7:0]  irq_vector,
  input wire cpu_status_t cpu_status,
  // System bus side.
  input wire logic        addr_latch_en,
  input wire logic [23:0] sys_addr,
  input wire bus_cmd_t    bus_cmd,
  input wire chip_sel_t   chip_sel,
  input wire logic        data_transceiver_enable,
  input wire logic        data_direction,
  input wire logic        byte_lane_low_en
);
  localparam int SLOW_LO = 8 + 5 * WAIT_STATES;
  logic [7:0] rst_cnt_r;
  logic [5:0] since_r;
  logic       slow_r;
  logic       ale_d_r;

  // Counts clocks of processor reset and clocks since each address phase began.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_cnt_r <= 8'h00;
      since_r   <= 6'h3F;
      slow_r    <= 1'b0;
      ale_d_r   <= 1'b0;
    end
    else
    begin
      ale_d_r   <= addr_latch_en;
      rst_cnt_r <= !cpu_reset ? 8'h00 : (rst_cnt_r == 8'hFF ? rst_cnt_r : rst_cnt_r + 8'h01);
      if (addr_latch_en && !ale_d_r)
      begin
        since_r <= 6'h01;
        slow_r  <= !(chip_sel.display_ctrl_sel_n && chip_sel.serial_keyboard_sel_n
                     && chip_sel.parallel_adapter_sel_n);
      end
      else if (since_r != 6'h3F)
        since_r <= since_r + 6'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence tick_gap;
    !cpu_clk_tick [*4] ##1 cpu_clk_tick;
  endsequence
  sequence ready_hold;
    !ready_n [*4] ##1 ready_n;
  endsequence

  a_tick_five_clocks: assert property (cpu_clk_tick |=> tick_gap)
    else $error("processor tick spacing wrong");
  a_ready_one_tick: assert property ($fell(ready_n) |=> ready_hold)
    else $error("ready pulse length wrong");
  a_ready_wait_count: assert property ($fell(ready_n) |-> (slow_r ?
    (since_r >= 6'(SLOW_LO) && since_r <= 6'(SLOW_LO + 4)) : (since_r inside {[8:12]})))
    else $error("ready came after the wrong number of waits");
  a_unmapped_no_ready: assert property ((&chip_sel) && data_transceiver_enable |-> ready_n)
    else $error("ready returned for an unmapped address");
  a_reset_long_enough: assert property ($fell(cpu_reset) |->
    rst_cnt_r >= 8'(5 * (RESET_HOLD_TICKS - 1)))
    else $error("processor reset released too early");
  a_test_forces_hold: assert property ($rose(run_test_selector) |-> ##[1:12] hold_request)
    else $error("hold request did not follow test position");
  a_addr_latched: assert property ($rose(addr_latch_en) |-> sys_addr == $past(cpu_status.addr))
    else $error("latched address differs from processor address");
  a_low_lane_a0: assert property (data_transceiver_enable |-> byte_lane_low_en == !sys_addr[0])
    else $error("low byte lane wrong");
  a_write_drives_out: assert property (data_transceiver_enable && data_direction |->
    !(bus_cmd.mem_write_n && bus_cmd.io_write_n) && !cpu_rdata_oe)
    else $error("transceiver direction wrong");
  a_mem_select_map: assert property (!bus_cmd.mem_read_n |->
    chip_sel.boot_memory_high_sel_n == (sys_addr[19:16] != 4'hF)
    && chip_sel.dram_low_bank_sel_n == (sys_addr[19:16] != 4'h0))
    else $error("memory select wrong");
  a_vector_on_bus: assert property ($fell(ready_n) && !bus_cmd.vector_ack_n |->
    cpu_rdata == {8'h00, irq_vector} && !chip_sel.vector_poll_sel_n)
    else $error("interrupt vector not supplied");
  a_hold_floats_data: assert property (bus_release_ack |-> !cpu_rdata_oe)
    else $error("data driven while bus released");
endmodule

bind cpu_bus_decode_control cpu_bus_checker #(
  .WAIT_STATES      (WAIT_STATES),
  .RESET_HOLD_TICKS (RESET_HOLD_TICKS)
) chk (.*);

// file: tb/cpu_model.sv
// Behavioural processor that runs bus cycles against the control block.
`timescale 1ns/1ps
module cpu_model
  import cpu_bus_pkg::*;
(
  // Clock and handshake.
  input  wire logic        clock,
  input  wire logic        cpu_clk_tick,
  input  wire logic        ready_n,
  input  wire logic        hold_request,
  input  wire logic [15:0] cpu_rdata,
  // Processor outputs.
  output cpu_status_t      cpu_status,
  output logic [15:0]      cpu_wdata,
  output logic             bus_release_ack
);
  initial
  begin
    cpu_status = {24'hFFFFFF, 1'b1, 1'b0, 1'b0, 2'h3};
    cpu_wdata = 16'h0000;
  end

  // Hold is granted on the processor clock after the request; the status lines stay driven.
  initial
  begin
    bus_release_ack = 1'b0;
    forever
    begin
      @(posedge clock);
      if (cpu_clk_tick)
        bus_release_ack <= hold_request;
    end
  end

  task automatic run_cycle(input logic [1:0] st, input logic mio, input logic cod,
                           input logic [23:0] a, input logic bhe, input logic [15:0] wd,
                           output logic ok, output logic [15:0] rd);
    int n;
    ok = 1'b0;
    rd = 16'h0000;
    n = 0;
    do
      @(posedge clock);
    while (!cpu_clk_tick);
    cpu_status <= {(mio ? a : {8'h00, a[15:0]}), bhe, mio, cod, st};
    cpu_wdata <= wd;
    do
      @(posedge clock);
    while (!cpu_clk_tick);
    cpu_status.cycle_status_1_n <= 1'b1;
    cpu_status.cycle_status_0_n <= 1'b1;
    while (!ok && n < 60)
    begin
      @(posedge clock);
      n++;
      if (cpu_clk_tick && !ready_n)
      begin
        ok = 1'b1;
        rd = cpu_rdata;
      end
    end
    cpu_wdata <= ~wd;
  endtask
endmodule

// file: tb/cpu_bus_decode_control_tb.sv
// Self-checking bench for the processor bus decode and control block.
`timescale 1ns/1ps
`include "cpu_bus_defines.svh"
module cpu_bus_decode_control_tb;
  import cpu_bus_pkg::*;
  localparam logic [23:0] REGION [11] = '{24'h000000, 24'h010000, 24'h020000, 24'h030000,
    24'h040000, 24'h050000, 24'h0E0000, 24'h0F0000, 24'h000000, 24'h002000, 24'h004000};
  logic        clock, resetn, reset_button, run_test_selector;
  logic        cpu_clk_tick, cpu_reset, hold_request, bus_release_ack, ready_n;
  logic        cpu_rdata_oe, addr_latch_en, data_transceiver_enable, data_direction;
  logic        byte_lane_low_en, byte_lane_high_en;
  logic [3:0]  test_switch;
  logic [7:0]  irq_vector;
  logic [15:0] cpu_wdata, cpu_rdata, status_led, sys_wdata, sys_rdata;
  logic [23:0] sys_addr;
  cpu_status_t cpu_status;
  bus_cmd_t    bus_cmd, cmd_q;
  chip_sel_t   chip_sel, sel_q;
  logic [1:0]  lane_q;
  logic        ok;
  logic [15:0] rd;
  int          num_errors, compares;

  cpu_bus_decode_control dut (.*);
  cpu_model cpu (.*);

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Keeps what the block showed in the address and command phases.
  always @(posedge clock)
  begin
    if (addr_latch_en)
      sel_q <= chip_sel;
    if (data_transceiver_enable)
    begin
      lane_q <= {byte_lane_high_en, byte_lane_low_en};
      cmd_q <= bus_cmd;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic test_reset();
    int n;
    n = 0;
    resetn <= 1'b0;
    repeat (4) @(posedge clock);
    check(cpu_reset, 1'b1);
    check(chip_sel, 11'h7FF);
    check(status_led, `LED_RESET_VALUE);
    resetn <= 1'b1;
    while (cpu_reset !== 1'b0 && n < 300)
    begin
      @(posedge clock);
      n++;
    end
    check(n >= 80, 1'b1);
  endtask

  // Walks every decoded region with word, low-byte and high-byte lanes in turn.
  task automatic test_regions();
    logic bhe, a0;
    for (int i = 0; i < 11; i++)
    begin
      bhe = (i % 3 == 1);
      a0 = (i % 3 == 2);
      cpu.run_cycle(`STATUS_READ, i < 8, i >= 7, REGION[i] | 24'(a0), bhe, 16'h0, ok, rd);
      check(ok, 1'b1);
      check(sel_q, 11'(~(11'h400 >> i)));
      check(lane_q, {~bhe, ~a0});
      check(cmd_q, i < 8 ? 5'h0F : 5'h1B);
      if (i == 10)
        check(rd, {12'h000, test_switch});
    end
  endtask

  task automatic test_led_write();
    cpu.run_cycle(`STATUS_WRITE, 1'b0, 1'b1, 24'h004000, 1'b0, 16'hA55A, ok, rd);
    check(status_led, 16'hA55A);
    check(cmd_q, 5'h1D);
    cpu.run_cycle(`STATUS_WRITE, 1'b0, 1'b1, 24'h004001, 1'b0, 16'h1234, ok, rd);
    check(status_led, 16'h125A);
    check(sys_wdata, 16'h1234);
  endtask

  task automatic test_vector();
    cpu.run_cycle(`STATUS_HALT_ACK, 1'b0, 1'b0, 24'h0, 1'b1, 16'h0, ok, rd);
    check(ok, 1'b1);
    check(rd, {8'h00, irq_vector});
    check(sel_q, 11'(~11'h080));
  endtask

  task automatic test_unmapped();
    cpu.run_cycle(`STATUS_READ, 1'b1, 1'b0, 24'h080000, 1'b0, 16'h0, ok, rd);
    check(ok, 1'b0);
    check(sel_q, 11'h7FF);
    test_reset();
  endtask

  // A press of the board reset button restarts the long processor reset.
  task automatic test_button_reset();
    int n;
    n = 0;
    reset_button <= 1'b1;
    repeat (10) @(posedge clock);
    check(cpu_reset, 1'b1);
    reset_button <= 1'b0;
    while (cpu_reset !== 1'b0 && n < 300)
    begin
      @(posedge clock);
      n++;
    end
    check(n >= 80, 1'b1);
    cpu.run_cycle(`STATUS_READ, 1'b1, 1'b0, 24'h000002, 1'b0, 16'h0, ok, rd);
    check(ok, 1'b1);
    check(rd, 16'h3C3C);
  endtask

  task automatic test_hold();
    int n;
    n = 0;
    run_test_selector <= 1'b1;
    while (hold_request !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    check(hold_request, 1'b1);
    repeat (10) @(posedge clock);
    check(bus_release_ack, 1'b1);
    cpu.run_cycle(`STATUS_READ, 1'b1, 1'b0, 24'h010000, 1'b0, 16'h0, ok, rd);
    check(ok, 1'b1);
    check(rd, 16'h3C3C);
    check(cpu_rdata_oe, 1'b0);
    run_test_selector <= 1'b0;
    repeat (20) @(posedge clock);
    check(hold_request, 1'b0);
  endtask

  initial
  begin
    resetn = 1'b0;
    reset_button = 1'b0;
    run_test_selector = 1'b0;
    test_switch = 4'hA;
    irq_vector = 8'h5C;
    sys_rdata = 16'h3C3C;
    test_reset();
    test_regions();
    test_led_write();
    test_vector();
    test_unmapped();
    test_button_reset();
    test_hold();
    final_report();
  end

  initial
  begin
    #(40000 * 25);
    num_errors++;
    final_report();
  end
endmodule
